// ### shared/lfm_pkg.sv
package lfm_pkg;
    // core clock rate and the unit in which the silence limit is counted
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned SILENCE_UNIT_US = 1000;
    // default count of core cycles per silence unit, derived from the rate
    localparam int unsigned SILENCE_UNIT_CYCLES_DEF = SILENCE_UNIT_US * CLK_MHZ;

    // accepted frame lengths in bits
    localparam logic [7:0] FRAME_LEN_A = 8'h40;
    localparam logic [7:0] FRAME_LEN_B = 8'h50;
    localparam logic [7:0] FRAME_LEN_C = 8'h60;
    localparam logic [7:0] FRAME_LEN_D = 8'h70;

    // fault counter width; its maximum is all ones
    localparam int unsigned CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic [CNT_W-1:0] CNT_RESET = '0;

    // bit positions in the write-one-to-clear mask of the fault status
    localparam int unsigned CLR_FRAME = 0;
    localparam int unsigned CLR_CHECKSUM = 1;
    localparam int unsigned CLR_SILENCE = 2;
    localparam int unsigned CLR_REPLY = 3;
    localparam int unsigned CLR_SATURATED = 4;
    localparam int unsigned CLR_W = 5;

    // silence limit field width
    localparam int unsigned SIL_W = 8;

    // register address and data fields of a response frame
    localparam int unsigned ADDR_W = 14;
    localparam logic [13:0] ERR_REGADDR = 14'h3fff;
    localparam logic [1:0] ERR_DATA0_TOP = 2'h0;
    localparam logic [15:0] PAD_ERROR = 16'h8000;
    localparam logic [15:0] PAD_NORMAL = 16'h0000;
    localparam int unsigned RDCNT_W = 8;

    // kind of the most recent bad access
    localparam logic [1:0] ACC_NONE = 2'h0;
    localparam logic [1:0] ACC_READ = 2'h1;
    localparam logic [1:0] ACC_WRITE = 2'h2;

    // multi-read response sequencer states
    typedef enum logic {
        LFM_RSP_IDLE,
        LFM_RSP_RUN
    } lfm_rsp_state_t;
endpackage

// ### hdl/lfm_unit_tick.sv
module lfm_unit_tick
    import lfm_pkg::*;
#(
    parameter int unsigned DIV = SILENCE_UNIT_CYCLES_DEF
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // divider runs only while enabled, restarts from zero otherwise
    input wire logic i_run,
    // one-cycle enable pulse every DIV cycles
    output logic o_tick
);
    localparam int unsigned DW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [DW-1:0] LAST = DW'(DIV - 1);

    logic [DW-1:0] div_cnt; // cycles since the last tick
    logic [DW-1:0] next_div_cnt;
    logic next_tick;

    // next value of the divider
    always_comb begin
        next_div_cnt = div_cnt;
        next_tick = 1'b0;
        if (!i_run) begin
            next_div_cnt = '0;
        end else if (div_cnt == LAST) begin
            next_div_cnt = '0;
            next_tick = 1'b1;
        end else begin
            next_div_cnt = div_cnt + DW'(1);
        end
    end

    // registers only
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_cnt <= '0;
            o_tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            o_tick <= next_tick;
        end
    end
endmodule

// ### hdl/lfm_host_link_fault_monitor.sv
// Notes on behaviour
// - each link fault adds one to counter
// - nonzero counter write clears it, zero ignored
// - counter saturates at max, sets saturated flag
// - each fault flag clears only on one-write
// - spi reply length mismatch sets flag, counts
// - silence beyond limit sets flag, counts
// - silence check can be switched off
// - bad checksum sets flag and counts
// - only 64/80/96/112-bit frames accepted
// - access to missing register is access fault
// - read-only writes, write-only reads are fine
// - error frame: address all ones, data0 address
// - error frames pad with 8000h, not zero
// - multi-read: error frames from first failure on
// - last bad access kind and address recorded
// - access faults leave the counter alone
// - faulty messages discarded; reply start is not gated by the verdict
module lfm_host_link_fault_monitor
    import lfm_pkg::*;
#(
    parameter int unsigned SILENCE_UNIT_CYCLES = SILENCE_UNIT_CYCLES_DEF
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // received message, checked by the frame front-end on this clock
    input wire logic i_msg_done,
    input wire logic [7:0] i_msg_bits,
    input wire logic i_msg_crc_ok,
    input wire logic i_spi_mode,
    input wire logic i_reply_pending,
    input wire logic [7:0] i_reply_bits,
    input wire logic i_msg_tx_done,
    // configuration
    input wire logic i_silence_check_off,
    input wire logic [SIL_W-1:0] i_silence_limit,
    // software writes to the fault status
    input wire logic i_sw_wr,
    input wire logic [CLR_W-1:0] i_sw_clear_mask,
    input wire logic [CNT_W-1:0] i_sw_cnt_wdata,
    // single register access check
    input wire logic i_acc_req,
    input wire logic i_acc_write,
    input wire logic [ADDR_W-1:0] i_acc_addr,
    input wire logic i_acc_exists,
    // multi-read response sequencing
    input wire logic i_rd_start,
    input wire logic [ADDR_W-1:0] i_rd_addr,
    input wire logic [RDCNT_W-1:0] i_rd_count,
    input wire logic i_rd_cancel,
    input wire logic i_rsp_take,
    input wire logic i_probe_exists,
    // message verdict
    output logic o_msg_execute,
    output logic o_msg_discard,
    // fault status
    output logic o_frame_length_fault_flag,
    output logic o_checksum_fault_flag,
    output logic o_reply_length_fault_flag,
    output logic o_link_silence_fault,
    output logic o_fault_counter_saturated_flag,
    output logic [CNT_W-1:0] o_link_fault_counter,
    // bad access record
    output logic o_access_fault,
    output logic [1:0] o_bad_access_kind,
    output logic [ADDR_W-1:0] o_bad_access_addr,
    // response frame fields
    output logic [ADDR_W-1:0] o_probe_addr,
    output logic o_rsp_busy,
    output logic o_rsp_valid,
    output logic o_rsp_error,
    output logic [ADDR_W-1:0] o_rsp_regaddr,
    output logic [15:0] o_rsp_data0,
    output logic [15:0] o_rsp_pad
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // true for the four accepted frame lengths
    function automatic logic len_ok(input logic [7:0] bits);
        len_ok = (bits == FRAME_LEN_A) || (bits == FRAME_LEN_B) ||
                 (bits == FRAME_LEN_C) || (bits == FRAME_LEN_D);
    endfunction

    // message classification, evaluated once per received message
    logic frame_bad; // length not accepted
    logic crc_bad; // length fine, checksum wrong
    logic reply_bad; // spi only: pending reply does not fit the frame
    logic msg_good; // message may execute
    always_comb begin
        frame_bad = i_msg_done && !len_ok(i_msg_bits);
        crc_bad = i_msg_done && len_ok(i_msg_bits) && !i_msg_crc_ok;
        reply_bad = i_msg_done && len_ok(i_msg_bits) && i_msg_crc_ok && i_spi_mode &&
                    i_reply_pending && (i_reply_bits != i_msg_bits);
        msg_good = i_msg_done && !frame_bad && !crc_bad && !reply_bad;
    end

    ////////////////////////////////////////////////////////////////////////////
    // silence watchdog

    logic unit_tick; // one pulse per silence unit
    logic [SIL_W-1:0] sil_cnt; // units since the last valid traffic
    logic [SIL_W-1:0] next_sil_cnt;
    logic sil_fire; // limit passed in this cycle

    // the divider is held while checking is off, so re-enabling starts clean
    lfm_unit_tick #(
        .DIV(SILENCE_UNIT_CYCLES)
    ) u_unit_tick (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_run(!i_silence_check_off),
        .o_tick(unit_tick)
    );

    // fire when a tick arrives with the limit already used up
    always_comb begin
        next_sil_cnt = sil_cnt;
        sil_fire = 1'b0;
        if (i_silence_check_off) begin
            next_sil_cnt = '0;
        end else if (msg_good || i_msg_tx_done) begin
            next_sil_cnt = '0; // valid traffic restarts the wait
        end else if (unit_tick) begin
            if (sil_cnt >= i_silence_limit) begin
                sil_fire = 1'b1;
                next_sil_cnt = '0;
            end else begin
                next_sil_cnt = sil_cnt + SIL_W'(1);
            end
        end
    end

    // registers only
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sil_cnt <= '0;
        end else begin
            sil_cnt <= next_sil_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault flags and counter

    logic [1:0] fault_events; // faults counted this cycle
    logic cnt_clear; // software asks for a counter restart
    logic [CNT_W:0] cnt_sum; // one bit wider to see overflow
    logic [CNT_W-1:0] next_cnt;
    logic next_frame_flag;
    logic next_crc_flag;
    logic next_reply_flag;
    logic next_sil_flag;
    logic next_sat_flag;
    logic next_execute;
    logic next_discard;

    // flags: an event in the clearing cycle wins over the clear
    always_comb begin
        // access faults are deliberately not part of this sum
        fault_events = 2'((frame_bad || crc_bad || reply_bad)) + 2'(sil_fire);
        cnt_clear = i_sw_wr && (i_sw_cnt_wdata != '0);
        cnt_sum = {1'b0, (cnt_clear ? CNT_RESET : o_link_fault_counter)} +
                  (CNT_W + 1)'(fault_events);
        if (cnt_sum > {1'b0, CNT_MAX}) begin
            next_cnt = CNT_MAX;
        end else begin
            next_cnt = cnt_sum[CNT_W-1:0];
        end
        // a counter already at max that sees another fault sets the saturated flag
        next_sat_flag = (o_link_fault_counter == CNT_MAX && fault_events != 2'h0) ||
                        (o_fault_counter_saturated_flag &&
                         !(i_sw_wr && i_sw_clear_mask[CLR_SATURATED]));
        next_frame_flag = frame_bad || (o_frame_length_fault_flag &&
                          !(i_sw_wr && i_sw_clear_mask[CLR_FRAME]));
        next_crc_flag = crc_bad || (o_checksum_fault_flag &&
                        !(i_sw_wr && i_sw_clear_mask[CLR_CHECKSUM]));
        next_reply_flag = reply_bad || (o_reply_length_fault_flag &&
                          !(i_sw_wr && i_sw_clear_mask[CLR_REPLY]));
        next_sil_flag = sil_fire || (o_link_silence_fault &&
                        !(i_sw_wr && i_sw_clear_mask[CLR_SILENCE]));
        next_execute = msg_good;
        next_discard = i_msg_done && !msg_good;
    end

    // registers only
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_link_fault_counter <= CNT_RESET;
            o_fault_counter_saturated_flag <= 1'b0;
            o_frame_length_fault_flag <= 1'b0;
            o_checksum_fault_flag <= 1'b0;
            o_reply_length_fault_flag <= 1'b0;
            o_link_silence_fault <= 1'b0;
            o_msg_execute <= 1'b0;
            o_msg_discard <= 1'b0;
        end else begin
            o_link_fault_counter <= next_cnt;
            o_fault_counter_saturated_flag <= next_sat_flag;
            o_frame_length_fault_flag <= next_frame_flag;
            o_checksum_fault_flag <= next_crc_flag;
            o_reply_length_fault_flag <= next_reply_flag;
            o_link_silence_fault <= next_sil_flag;
            o_msg_execute <= next_execute;
            o_msg_discard <= next_discard;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access check and multi-read response sequencer

    lfm_rsp_state_t rsp_state;
    lfm_rsp_state_t next_rsp_state;
    logic [RDCNT_W-1:0] rd_left; // frames still owed
    logic [RDCNT_W-1:0] next_rd_left;
    logic rd_failed; // a frame of this sequence already failed
    logic next_rd_failed;
    logic [ADDR_W-1:0] next_probe_addr;
    logic frame_err; // frame being built is an error frame
    logic next_rsp_valid;
    logic next_rsp_error;
    logic [ADDR_W-1:0] next_rsp_regaddr;
    logic [15:0] next_rsp_data0;
    logic [15:0] next_rsp_pad;
    logic next_acc_fault;
    logic [1:0] next_acc_kind;
    logic [ADDR_W-1:0] next_acc_addr;

    // one frame per take; once a frame fails, all later ones are error frames
    always_comb begin
        next_rsp_state = rsp_state;
        next_rd_left = rd_left;
        next_rd_failed = rd_failed;
        next_probe_addr = o_probe_addr;
        next_rsp_valid = 1'b0;
        next_rsp_error = o_rsp_error;
        next_rsp_regaddr = o_rsp_regaddr;
        next_rsp_data0 = o_rsp_data0;
        next_rsp_pad = o_rsp_pad;
        next_acc_fault = 1'b0;
        next_acc_kind = o_bad_access_kind;
        next_acc_addr = o_bad_access_addr;
        frame_err = rd_failed || !i_probe_exists;
        // existence alone decides; access direction only sets the recorded kind
        if (i_acc_req && !i_acc_exists) begin
            next_acc_fault = 1'b1;
            next_acc_kind = i_acc_write ? ACC_WRITE : ACC_READ;
            next_acc_addr = i_acc_addr;
        end
        case (rsp_state)
            LFM_RSP_IDLE: begin
                // any i_rd_start with a nonzero count starts a reply; the message verdict is not checked here
                if (i_rd_start && i_rd_count != '0) begin
                    next_rsp_state = LFM_RSP_RUN;
                    next_rd_left = i_rd_count;
                    next_rd_failed = 1'b0;
                    next_probe_addr = i_rd_addr;
                end
            end
            LFM_RSP_RUN: begin
                if (i_rd_cancel) begin
                    next_rsp_state = LFM_RSP_IDLE; // other commands drop pending data
                end else if (i_rsp_take) begin
                    next_rsp_valid = 1'b1;
                    next_rsp_error = frame_err;
                    if (frame_err) begin
                        next_rsp_regaddr = ERR_REGADDR;
                        next_rsp_data0 = {ERR_DATA0_TOP, o_probe_addr};
                        next_rsp_pad = PAD_ERROR;
                        next_rd_failed = 1'b1;
                        if (!rd_failed) begin
                            next_acc_fault = 1'b1; // first failure is the recorded one
                            next_acc_kind = ACC_READ;
                            next_acc_addr = o_probe_addr;
                        end
                    end else begin
                        next_rsp_regaddr = o_probe_addr;
                        next_rsp_data0 = PAD_NORMAL; // data itself comes from the reg file
                        next_rsp_pad = PAD_NORMAL;
                    end
                    next_probe_addr = o_probe_addr + ADDR_W'(1);
                    next_rd_left = rd_left - RDCNT_W'(1);
                    if (rd_left == RDCNT_W'(1)) begin
                        next_rsp_state = LFM_RSP_IDLE;
                    end
                end
            end
            default: begin
                next_rsp_state = LFM_RSP_IDLE;
            end
        endcase
    end

    // registers only
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rsp_state <= LFM_RSP_IDLE;
            rd_left <= '0;
            rd_failed <= 1'b0;
            o_probe_addr <= '0;
            o_rsp_busy <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_error <= 1'b0;
            o_rsp_regaddr <= '0;
            o_rsp_data0 <= PAD_NORMAL;
            o_rsp_pad <= PAD_NORMAL;
            o_access_fault <= 1'b0;
            o_bad_access_kind <= ACC_NONE;
            o_bad_access_addr <= '0;
        end else begin
            rsp_state <= next_rsp_state;
            rd_left <= next_rd_left;
            rd_failed <= next_rd_failed;
            o_probe_addr <= next_probe_addr;
            o_rsp_busy <= (next_rsp_state == LFM_RSP_RUN);
            o_rsp_valid <= next_rsp_valid;
            o_rsp_error <= next_rsp_error;
            o_rsp_regaddr <= next_rsp_regaddr;
            o_rsp_data0 <= next_rsp_data0;
            o_rsp_pad <= next_rsp_pad;
            o_access_fault <= next_acc_fault;
            o_bad_access_kind <= next_acc_kind;
            o_bad_access_addr <= next_acc_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_bad_len;
        i_msg_done && !len_ok(i_msg_bits);
    endsequence

    sequence s_one_fault_no_clear;
        (fault_events == 2'h1) && !cnt_clear && (o_link_fault_counter < CNT_MAX - 1);
    endsequence

    sequence s_err_frame_out;
        o_rsp_valid && o_rsp_error;
    endsequence

    AST_FRAME_FLAG: assert property (s_bad_len |=> o_frame_length_fault_flag && o_msg_discard)
        else $error("bad frame length not flagged");

    AST_CRC_FLAG: assert property (crc_bad |=> o_checksum_fault_flag && !o_msg_execute)
        else $error("checksum fault not flagged");

    AST_REPLY_FLAG: assert property (i_msg_done && len_ok(i_msg_bits) && i_msg_crc_ok &&
        !i_spi_mode |=> !$rose(o_reply_length_fault_flag))
        else $error("reply length fault outside spi mode");

    AST_DISCARD: assert property (o_msg_discard |-> !o_msg_execute ##1 !o_rsp_busy[*2])
        else $error("faulty message executed or answered");

    AST_COUNT_UP: assert property (s_one_fault_no_clear |=>
        o_link_fault_counter == $past(o_link_fault_counter) + CNT_W'(1))
        else $error("fault counter did not step by one");

    AST_COUNT_CLEAR: assert property (cnt_clear && fault_events == 2'h0 |=>
        o_link_fault_counter == CNT_RESET)
        else $error("nonzero write did not clear counter");

    AST_COUNT_ZERO_WRITE: assert property (i_sw_wr && i_sw_cnt_wdata == '0 &&
        fault_events == 2'h0 |=> $stable(o_link_fault_counter))
        else $error("zero write changed counter");

    AST_SATURATE: assert property (o_link_fault_counter == CNT_MAX && fault_events != 2'h0 |=>
        o_link_fault_counter == CNT_MAX && o_fault_counter_saturated_flag)
        else $error("counter did not saturate with flag");

    AST_W1C_ONLY: assert property ($fell(o_frame_length_fault_flag) |->
        $past(i_sw_wr && i_sw_clear_mask[CLR_FRAME]))
        else $error("frame flag cleared without one-write");

    AST_SILENCE_OFF: assert property (i_silence_check_off |=> !$rose(o_link_silence_fault))
        else $error("silence fault while check is off");

    AST_ACCESS_NO_COUNT: assert property (i_acc_req && !i_acc_exists && fault_events == 2'h0 &&
        !cnt_clear && !i_rsp_take |=> $stable(o_link_fault_counter) && o_access_fault &&
        o_bad_access_addr == $past(i_acc_addr))
        else $error("access fault touched counter");

    AST_ERR_FRAME_FIELDS: assert property (s_err_frame_out |-> o_rsp_regaddr == ERR_REGADDR &&
        o_rsp_data0[15:14] == ERR_DATA0_TOP && o_rsp_pad == PAD_ERROR)
        else $error("error frame fields wrong");

    AST_ERR_STAYS: assert property (rd_failed && rsp_state == LFM_RSP_RUN && i_rsp_take &&
        !i_rd_cancel |=> s_err_frame_out)
        else $error("readable frame after error frame");
endmodule

// ### bench/lfm_host_model.sv
module lfm_host_model (
    // clock
    input wire logic i_core_clk,
    // message lines toward the monitor
    output logic o_msg_done,
    output logic [7:0] o_msg_bits,
    output logic o_msg_crc_ok,
    output logic o_spi_mode,
    output logic o_reply_pending,
    output logic [7:0] o_reply_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle link: no message, spi operation at start
    initial begin
        {o_msg_done, o_msg_crc_ok, o_reply_pending, o_msg_bits, o_reply_bits} = 19'h0_0000;
        o_spi_mode = 1'b1;
    end
    // one message with its length, checksum verdict and pending reply
    task automatic send(input logic [7:0] len, input logic crc, input logic misfit);
        @(negedge i_core_clk);
        o_msg_done = 1'b1;
        o_msg_bits = len;
        o_msg_crc_ok = crc;
        o_reply_pending = 1'b1;
        // the reply is sized to fit unless a scenario asks otherwise
        o_reply_bits = misfit ? len + 8'h10 : len;
        @(negedge i_core_clk);
        // qualifiers are stale outside a message, so scramble them
        o_msg_done = 1'b0;
        o_msg_bits = ~o_msg_bits;
        o_msg_crc_ok = ~o_msg_crc_ok;
        o_reply_pending = 1'b0;
    endtask
endmodule

// ### bench/tb_top.sv
module tb_top;
    import lfm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // short silence unit keeps the run brief
    localparam int unsigned UNIT = 4;
    logic core_clk, reset_n, msg_done, crc_ok, spi_mode, reply_pending, check_off, sw_wr;
    logic acc_req, acc_write, acc_exists, rd_start, rsp_take, probe_exists;
    logic execute, discard, acc_fault, rsp_busy, rsp_valid, rsp_error;
    logic [7:0] msg_bits, reply_bits;
    logic [SIL_W-1:0] sil_limit;
    logic [CLR_W-1:0] clr_mask, flags, exp_flags;
    logic [CNT_W-1:0] cnt_wdata, exp_cnt, fault_cnt;
    logic [ADDR_W-1:0] acc_addr, rd_addr, probe_addr, bad_addr, rsp_regaddr;
    logic [RDCNT_W-1:0] rd_count;
    logic [1:0] bad_kind;
    logic [15:0] rsp_data0, rsp_pad;
    int miscompares, n_tests, n_exec, n_disc, seed, k;
    ////////////////////////////////////////////////////////////////////////////////
    lfm_host_model host (.i_core_clk(core_clk), .o_msg_done(msg_done), .o_msg_bits(msg_bits),
        .o_msg_crc_ok(crc_ok), .o_spi_mode(spi_mode), .o_reply_pending(reply_pending),
        .o_reply_bits(reply_bits));
    lfm_host_link_fault_monitor #(.SILENCE_UNIT_CYCLES(UNIT)) dut (.i_core_clk(core_clk),
        .i_reset_n(reset_n), .i_msg_done(msg_done), .i_msg_bits(msg_bits),
        .i_msg_crc_ok(crc_ok), .i_spi_mode(spi_mode), .i_reply_pending(reply_pending),
        .i_reply_bits(reply_bits), .i_msg_tx_done(1'b0), .i_silence_check_off(check_off),
        .i_silence_limit(sil_limit), .i_sw_wr(sw_wr), .i_sw_clear_mask(clr_mask),
        .i_sw_cnt_wdata(cnt_wdata), .i_acc_req(acc_req), .i_acc_write(acc_write),
        .i_acc_addr(acc_addr), .i_acc_exists(acc_exists), .i_rd_start(rd_start),
        .i_rd_addr(rd_addr), .i_rd_count(rd_count), .i_rd_cancel(1'b0),
        .i_rsp_take(rsp_take), .i_probe_exists(probe_exists), .o_msg_execute(execute),
        .o_msg_discard(discard), .o_frame_length_fault_flag(flags[CLR_FRAME]),
        .o_checksum_fault_flag(flags[CLR_CHECKSUM]), .o_link_silence_fault(flags[CLR_SILENCE]),
        .o_reply_length_fault_flag(flags[CLR_REPLY]),
        .o_fault_counter_saturated_flag(flags[CLR_SATURATED]),
        .o_link_fault_counter(fault_cnt), .o_access_fault(acc_fault),
        .o_bad_access_kind(bad_kind), .o_bad_access_addr(bad_addr), .o_probe_addr(probe_addr),
        .o_rsp_busy(rsp_busy), .o_rsp_valid(rsp_valid), .o_rsp_error(rsp_error),
        .o_rsp_regaddr(rsp_regaddr), .o_rsp_data0(rsp_data0), .o_rsp_pad(rsp_pad));
    // register file stand-in: only the second read address is missing
    assign probe_exists = (probe_addr !== rd_addr + 14'h0001);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // verdict pulses are counted, not timed
    always @(posedge core_clk) begin
        if (execute === 1'b1) n_exec++;
        if (discard === 1'b1) n_disc++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one message; fbit is the flag it should raise, or -1 when it is good
    task automatic msg(input logic [7:0] len, input logic crc, input logic misfit, input int fbit);
        int e0 = n_exec, d0 = n_disc;
        host.send(len, crc, misfit);
        repeat (2) @(negedge core_clk);
        if (fbit >= 0) begin
            if (exp_cnt == CNT_MAX) exp_flags[CLR_SATURATED] = 1'b1;
            else exp_cnt = exp_cnt + 1'b1;
            exp_flags[fbit] = 1'b1;
        end
        chk("execute count", e0 + (fbit < 0), n_exec);
        chk("discard count", d0 + (fbit >= 0), n_disc);
        chk("fault flags", exp_flags, flags);
        chk("fault counter", exp_cnt, fault_cnt);
    endtask
    task automatic swr(input logic [CLR_W-1:0] m, input logic [CNT_W-1:0] c);
        @(negedge core_clk);
        {sw_wr, clr_mask, cnt_wdata} = {1'b1, m, c};
        @(negedge core_clk);
        sw_wr = 1'b0;
        @(negedge core_clk);
        exp_flags = exp_flags & ~m;
        if (c != 0) exp_cnt = '0;
        chk("flags after write", exp_flags, flags);
        chk("counter after write", exp_cnt, fault_cnt);
    endtask
    task automatic acc(input logic w, input logic ex);
        logic seen;
        logic [ADDR_W-1:0] a;
        a = ADDR_W'($urandom);
        @(negedge core_clk);
        {acc_req, acc_write, acc_exists, acc_addr} = {1'b1, w, ex, a};
        @(negedge core_clk);
        acc_req = 1'b0;
        seen = 1'b0;
        repeat (3) begin
            if (acc_fault === 1'b1) seen = 1'b1;
            @(negedge core_clk);
        end
        chk("access fault", !ex, seen);
        if (!ex) chk("access kind", w ? ACC_WRITE : ACC_READ, bad_kind);
        if (!ex) chk("access addr", a, bad_addr);
        chk("counter after access", exp_cnt, fault_cnt);
    endtask
    // take frame f of the running read; from index 1 on they are error frames
    task automatic take(input int f);
        logic seen;
        logic err;
        logic [ADDR_W-1:0] a;
        a = rd_addr + ADDR_W'(f);
        err = (f >= 1);
        @(negedge core_clk);
        rsp_take = 1'b1;
        @(negedge core_clk);
        rsp_take = 1'b0;
        seen = 1'b0;
        repeat (3) begin
            if (rsp_valid === 1'b1) seen = 1'b1;
            @(negedge core_clk);
        end
        chk("frame valid", 1, seen);
        chk("frame error", err, rsp_error);
        chk("frame regaddr", err ? ERR_REGADDR : a, rsp_regaddr);
        chk("frame pad", err ? PAD_ERROR : PAD_NORMAL, rsp_pad);
        if (err) chk("frame data0", {ERR_DATA0_TOP, a}, rsp_data0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, sw_wr, acc_req, acc_write, rd_start, rsp_take} = 6'h00;
        {check_off, acc_exists, sil_limit, clr_mask, cnt_wdata} = {2'h3, 8'h01, 5'h00, 8'h00};
        {acc_addr, rd_addr, rd_count, exp_cnt, exp_flags} = '0;
        seed = $urandom(32'ha96f1e32);
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
        chk("reset counter", 0, fault_cnt);
        for (k = 0; k < 4; k++) msg(8'({FRAME_LEN_D, FRAME_LEN_C, FRAME_LEN_B,
            FRAME_LEN_A} >> (8 * k)), 1'b1, 1'b0, -1);
        for (k = 0; k < 4; k++) msg(8'($urandom) | 8'h01, 1'b1, 1'b0, CLR_FRAME);
        msg(FRAME_LEN_B, 1'b0, 1'b0, CLR_CHECKSUM);
        msg(FRAME_LEN_C, 1'b1, 1'b1, CLR_REPLY);
        host.o_spi_mode = 1'b0;
        msg(FRAME_LEN_C, 1'b1, 1'b1, -1);
        host.o_spi_mode = 1'b1;
        swr(5'h00, 8'h00);
        swr(5'h02, 8'h00);
        swr(5'h09, 8'h01);
        for (k = 0; k < 257; k++) msg(8'h41, 1'b1, 1'b0, CLR_FRAME);
        swr(5'h1f, 8'hff);
        msg(FRAME_LEN_A, 1'b1, 1'b0, -1);
        check_off = 1'b0;
        repeat (UNIT - 1) @(negedge core_clk);
        chk("early silence", 0, flags[CLR_SILENCE]);
        for (k = 0; k < 60 && flags[CLR_SILENCE] !== 1'b1; k++) @(negedge core_clk);
        check_off = 1'b1;
        exp_cnt = exp_cnt + 1'b1;
        exp_flags[CLR_SILENCE] = 1'b1;
        chk("silence flags", exp_flags, flags);
        chk("silence counter", exp_cnt, fault_cnt);
        swr(5'h04, 8'h00);
        repeat (40) @(negedge core_clk);
        chk("silence while off", exp_flags, flags);
        for (k = 0; k < 4; k++) acc(k[0], k[1]);
        msg(FRAME_LEN_D, 1'b1, 1'b0, -1);
        rd_addr = ADDR_W'($urandom % 32'h3f00);
        @(negedge core_clk);
        {rd_start, rd_count} = {1'b1, 8'h03};
        @(negedge core_clk);
        rd_start = 1'b0;
        for (k = 0; k < 3; k++) take(k);
        chk("read fault addr", rd_addr + 14'h0001, bad_addr);
        chk("read fault kind", ACC_READ, bad_kind);
        chk("busy after read", 0, rsp_busy);
        chk("counter after read", exp_cnt, fault_cnt);
        close_out();
    end
    initial begin
        #2_000_000;
        miscompares++;
        close_out();
    end
endmodule
